/* hsp_cfg.svh */
// constants for the host serial port with power-mode control
// assumes a single 50 MHz clock; included by the core and the bench
`ifndef HSP_CFG_SVH
`define HSP_CFG_SVH
`define HSP_CLK_HZ 50000000
`define HSP_DIV(b) ((`HSP_CLK_HZ + (b) / 2) / (b))
// line rate selector codes and their divisors
`define HSP_BAUD_9600   3'h0
`define HSP_BAUD_19200  3'h1
`define HSP_BAUD_38400  3'h2
`define HSP_BAUD_57600  3'h3
`define HSP_BAUD_115200 3'h4
`define HSP_BAUD_230400 3'h5
`define HSP_BAUD_921600 3'h6
`define HSP_WORD_LEN    4'h8
`define HSP_PAR_NONE    2'h0
`define HSP_PAR_EVEN    2'h1
`define HSP_PAR_ODD     2'h2
// power modes
`define HSP_PM0 3'h0
`define HSP_PM1 3'h1
`define HSP_PM2 3'h2
`define HSP_PM5 3'h5
// register byte addresses
`define HSP_REG_CMD    8'h00
`define HSP_REG_STATUS 8'h04
`define HSP_REG_RESP   8'h08
`define HSP_REG_TXDATA 8'h0C
`define HSP_REG_RXDATA 8'h10
`define HSP_REG_CFG    8'h14
`define HSP_REG_LINES  8'h18
// command codes
`define HSP_OP_SERCFG 8'h01
`define HSP_OP_PWR    8'h02
`define HSP_OP_HWADDR 8'h03
`define HSP_OP_VER    8'h04
`define HSP_OP_OUT    8'h05
`define HSP_OP_IN     8'h06
`define HSP_OP_HIGH   8'h07
`define HSP_OP_LOW    8'h08
`define HSP_OP_SAMPLE 8'h09
`define HSP_OP_KEY    8'h0A
`define HSP_OP_CHAN   8'h0B
`define HSP_OP_REGION 8'h0C
`define HSP_OP_BSS    8'h0D
`define HSP_OP_MODEM  8'h0E
// key lengths in hex digits, channel limits per region
`define HSP_KEY64_DIGITS  5'h0A
`define HSP_KEY128_DIGITS 5'h1A
`define HSP_CH_MAX_R0 5'h0B
`define HSP_CH_MAX_R1 5'h0D
`define HSP_CH_MAX_R2 5'h0E
// shared line positions: lines 10..13 sit at indices 8..11
`define HSP_SHARED_MASK 12'hF00
`define HSP_IDX_DSR 8
`define HSP_IDX_DTR 9
`define HSP_IDX_RI  10
`define HSP_IDX_DCD 11
// start-up delay before flow control is first asserted
`define HSP_READY_NS  1000
`define HSP_READY_CYC ((`HSP_READY_NS * (`HSP_CLK_HZ / 1000000) + 999) / 1000)
`endif

/* hsp_pkg.sv */
// types for the host serial port with power-mode control
// assumes hsp_cfg.svh is on the include path
package hsp_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
  } hsp_tx_st_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
    RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
  } hsp_rx_st_t;
  typedef enum logic [1:0] {PW_RUN = 2'b01, PW_STBY = 2'b10} hsp_pw_st_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } hsp_bus_req_t;
  typedef struct packed {
    logic [2:0] baud;
    logic [1:0] parity;
    logic       stop2;
  } hsp_ser_cfg_t;
  typedef struct packed {
    logic on;
    logic riOut;
    logic dcdOut;
    logic riLvl;
    logic dcdLvl;
  } hsp_modem_cfg_t;
  typedef struct packed {
    logic [13:0]    syn1;
    logic [13:0]    syn2;
    hsp_tx_st_t     txSt;
    logic [12:0]    txCnt;
    logic [2:0]     txBit;
    logic [7:0]     txShift;
    logic           txPar;
    logic [7:0]     txData;
    logic           txPend;
    logic           txLine;
    hsp_rx_st_t     rxSt;
    logic [12:0]    rxCnt;
    logic [2:0]     rxBit;
    logic [7:0]     rxShift;
    logic           rxPar;
    logic [7:0]     rxData;
    logic           rxValid;
    logic           rxOvr;
    logic           rxParErr;
    logic           rxFrmErr;
    hsp_ser_cfg_t   cfg;
    hsp_pw_st_t     pwSt;
    logic [2:0]     pwrMode;
    logic           adhoc;
    logic [1:0]     region;
    logic [4:0]     channel;
    logic           keySet;
    logic           key128;
    logic [11:0]    lineDir;
    logic [11:0]    lineVal;
    hsp_modem_cfg_t modem;
    logic [5:0]     readyCnt;
    logic           ready;
    logic           rtsN;
    logic           respErr;
    logic [23:0]    respData;
    logic [31:0]    rdData;
  } hsp_state_t;
endpackage : hsp_pkg

/* hsp_serial_port.sv */
// host serial port: configurable async line, flow control, power modes,
// command acceptance and general-purpose lines
// assumes one 50 MHz clock, synchronous reset, pins already at logic level
//
// Function
// R1 - power-up line is 115200, 8, none, 1
// R2 - rate set only by command, listed rates
// R3 - word length must be eight bits
// R4 - none, even or odd parity; 1/2 stops
// R5 - flow-control output low means can receive
// R6 - transmit only while host input is low
// R7 - host stops sending when output deasserted
// R8 - mode 2: permit released, controller sleeps
// R9 - wake on packet or permit reasserted
// R10 - start in mode 5, chipset off
// R11 - mode 5 accepts four commands only
// R12 - power mode values 0,1,2,5 only
// R13 - mode 1: chipset dozes, controller awake
// R14 - refuse mode 1 while in ad-hoc
// R15 - each line settable input or output
// R16 - lines 10-13 modem or general, not both
// R17 - drive high, drive low, sample lines
// R18 - ring/carrier direction and level selectable
// R19 - key of 10 or 26 digits
// R20 - channel limit follows configured region
// R21 - flow control held off until ready
// R22 - unshared lines are inputs at reset
// R23 - reset input is active high
// R24 - finish character, then idle while held
// R25 - refused command answers error, no change
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "hsp_cfg.svh"
module hsp_serial_port #(
  parameter logic [23:0] HW_ADDR = 24'h000001, // arbitrary value
  parameter logic [23:0] VERSION = 24'h000100  // arbitrary value
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire hsp_pkg::hsp_bus_req_t busReq,
  output logic [31:0]                busRdata,
  input  wire logic                  serRxd,
  output logic                       serTxd,
  input  wire logic                  ctsN,
  output logic                       rtsN,
  input  wire logic [11:0]           lineIn,
  output logic [11:0]                lineOut,
  output logic [11:0]                lineOe,
  input  wire logic                  apPacket,
  output logic                       chipsetOn,
  output logic                       chipsetDoze,
  output logic                       ctrlStandby
);
  hsp_pkg::hsp_state_t q;
  hsp_pkg::hsp_state_t n;
  logic [12:0] div;
  logic        rxIn;
  logic        ctsOk;
  logic        dsrOn;
  logic        cmdWr;
  logic        ok;
  logic [7:0]  op;
  logic [23:0] arg;
  logic [4:0]  chMax;

  // divisor of the selected rate
  always_comb begin
    case (q.cfg.baud)
      `HSP_BAUD_9600:   div = 13'(`HSP_DIV(9600));
      `HSP_BAUD_19200:  div = 13'(`HSP_DIV(19200));
      `HSP_BAUD_38400:  div = 13'(`HSP_DIV(38400));
      `HSP_BAUD_57600:  div = 13'(`HSP_DIV(57600));
      `HSP_BAUD_230400: div = 13'(`HSP_DIV(230400));
      `HSP_BAUD_921600: div = 13'(`HSP_DIV(921600));
      default:          div = 13'(`HSP_DIV(115200));
    endcase
  end

  // synchronised pins; permit counts as held while lines are general
  assign rxIn  = q.syn2[12];
  assign ctsOk = !q.syn2[13];
  assign dsrOn = !q.modem.on || !q.syn2[`HSP_IDX_DSR];
  assign cmdWr = busReq.wr && busReq.addr == `HSP_REG_CMD;
  assign op    = busReq.wdata[7:0];
  assign arg   = busReq.wdata[31:8];

  always_comb begin
    case (q.region)
      2'h0:    chMax = `HSP_CH_MAX_R0;
      2'h1:    chMax = `HSP_CH_MAX_R1;
      2'h2:    chMax = `HSP_CH_MAX_R2;
      default: chMax = 5'h00;
    endcase
  end

  // next state of the whole block
  always_comb begin
    n = q;
    ok = 1'b1;
    n.syn1 = {ctsN, serRxd, lineIn};
    n.syn2 = q.syn1;
    n.rdData = 32'h0000_0000;
    // command decode; any refusal leaves the state alone
    if (cmdWr) begin
      if (q.pwrMode == `HSP_PM5 && op != `HSP_OP_SERCFG && // see R11
          op != `HSP_OP_PWR && op != `HSP_OP_HWADDR && op != `HSP_OP_VER)
        ok = 1'b0;
      else begin
        case (op)
          `HSP_OP_SERCFG: begin
            // rate only by command, no auto detect
            if (arg[2:0] > `HSP_BAUD_921600 || // see R2
                arg[6:3] != `HSP_WORD_LEN ||   // see R3
                arg[8:7] > `HSP_PAR_ODD)       // see R4
              ok = 1'b0;
            else
              n.cfg = {arg[2:0], arg[8:7], arg[9]};
          end
          `HSP_OP_PWR: begin
            if (arg[2:0] != `HSP_PM0 && arg[2:0] != `HSP_PM1 && // see R12
                arg[2:0] != `HSP_PM2 && arg[2:0] != `HSP_PM5)
              ok = 1'b0;
            else if (arg[2:0] == `HSP_PM1 && q.adhoc) // see R14
              ok = 1'b0;
            else
              n.pwrMode = arg[2:0];
          end
          `HSP_OP_HWADDR: n.respData = HW_ADDR;
          `HSP_OP_VER:    n.respData = VERSION;
          `HSP_OP_OUT, `HSP_OP_IN: begin
            // shared lines belong to the modem while it owns them
            if (q.modem.on && |(arg[11:0] & `HSP_SHARED_MASK)) // see R16
              ok = 1'b0;
            else if (op == `HSP_OP_OUT)
              n.lineDir = q.lineDir | arg[11:0]; // see R15
            else
              n.lineDir = q.lineDir & ~arg[11:0];
          end
          `HSP_OP_HIGH: n.lineVal = q.lineVal | arg[11:0]; // see R17
          `HSP_OP_LOW:  n.lineVal = q.lineVal & ~arg[11:0];
          `HSP_OP_SAMPLE:
            n.respData = {12'h000, arg[11:0] & q.syn2[11:0]};
          `HSP_OP_KEY: begin
            if (arg[4:0] == `HSP_KEY64_DIGITS) begin // see R19
              n.keySet = 1'b1;
              n.key128 = 1'b0;
            end else if (arg[4:0] == `HSP_KEY128_DIGITS) begin
              n.keySet = 1'b1;
              n.key128 = 1'b1;
            end else
              ok = 1'b0;
          end
          `HSP_OP_CHAN: begin
            if (arg[4:0] == 5'h00 || arg[4:0] > chMax) // see R20
              ok = 1'b0;
            else
              n.channel = arg[4:0];
          end
          `HSP_OP_REGION: begin
            if (arg[1:0] == 2'h3)
              ok = 1'b0;
            else
              n.region = arg[1:0];
          end
          `HSP_OP_BSS: begin
            if (arg[0] && q.pwrMode == `HSP_PM1) // see R14
              ok = 1'b0;
            else
              n.adhoc = arg[0];
          end
          `HSP_OP_MODEM: begin
            n.modem = arg[4:0]; // see R18
            // shared lines fall back to inputs whenever the written dcdLvl bit (arg[0]) is low
            if (!arg[0])
              n.lineDir = q.lineDir & ~`HSP_SHARED_MASK;
          end
          default: ok = 1'b0;
        endcase
      end
      n.respErr = !ok; // see R25
    end
    // transmit holding register; a write while full is dropped
    if (busReq.wr && busReq.addr == `HSP_REG_TXDATA && !q.txPend) begin
      n.txData = busReq.wdata[7:0];
      n.txPend = 1'b1;
    end
    // write ones to clear receive error flags
    if (busReq.wr && busReq.addr == `HSP_REG_STATUS) begin
      n.rxOvr    = q.rxOvr & ~busReq.wdata[8];
      n.rxParErr = q.rxParErr & ~busReq.wdata[9];
      n.rxFrmErr = q.rxFrmErr & ~busReq.wdata[10];
    end
    // register reads, answered in the next cycle
    if (busReq.rd) begin
      case (busReq.addr)
        `HSP_REG_STATUS:
          n.rdData = {20'h00000, q.adhoc, q.rxFrmErr, q.rxParErr, q.rxOvr,
                      q.rxValid, q.txPend, q.pwrMode,
                      q.pwSt == hsp_pkg::PW_STBY, q.ready, q.respErr};
        `HSP_REG_RESP:   n.rdData = {8'h00, q.respData};
        `HSP_REG_RXDATA: begin
          n.rdData = {23'h000000, q.rxValid, q.rxData};
          n.rxValid = 1'b0;
        end
        `HSP_REG_CFG:
          n.rdData = {14'h0000, q.keySet, q.key128, q.channel, q.modem,
                      q.cfg};
        `HSP_REG_LINES:  n.rdData = {8'h00, q.lineDir, q.syn2[11:0]};
        default:         n.rdData = 32'h0000_0000;
      endcase
    end
    // transmitter; the host input is looked at only between characters
    case (q.txSt)
      hsp_pkg::TX_IDLE: begin
        n.txLine = 1'b1;
        if (q.txPend && ctsOk) begin // see R6
          n.txSt    = hsp_pkg::TX_START;
          n.txCnt   = div - 13'h0001;
          n.txShift = q.txData;
          n.txPar   = (q.cfg.parity == `HSP_PAR_ODD) ? ~^q.txData
                                                     : ^q.txData;
          n.txPend  = 1'b0;
          n.txLine  = 1'b0;
        end
      end
      hsp_pkg::TX_START, hsp_pkg::TX_DATA, hsp_pkg::TX_PAR: begin
        if (q.txCnt != 13'h0000)
          n.txCnt = q.txCnt - 13'h0001;
        else begin
          n.txCnt = div - 13'h0001;
          if (q.txSt == hsp_pkg::TX_START) begin
            n.txSt   = hsp_pkg::TX_DATA;
            n.txBit  = 3'h0;
            n.txLine = q.txShift[0];
          end else if (q.txSt == hsp_pkg::TX_DATA && q.txBit != 3'h7) begin
            n.txBit   = q.txBit + 3'h1;
            n.txShift = {1'b0, q.txShift[7:1]};
            n.txLine  = q.txShift[1];
          end else if (q.txSt == hsp_pkg::TX_DATA &&
                       q.cfg.parity != `HSP_PAR_NONE) begin
            n.txSt   = hsp_pkg::TX_PAR; // see R4
            n.txLine = q.txPar;
          end else begin
            n.txSt   = hsp_pkg::TX_STOP;
            n.txBit  = {2'h0, q.cfg.stop2};
            n.txLine = 1'b1;
          end
        end
      end
      hsp_pkg::TX_STOP: begin
        // a stalled host still gets this whole character
        if (q.txCnt != 13'h0000)
          n.txCnt = q.txCnt - 13'h0001;
        else if (q.txBit != 3'h0) begin
          n.txBit = 3'h0;
          n.txCnt = div - 13'h0001;
        end else
          n.txSt = hsp_pkg::TX_IDLE; // see R24
      end
      default: n.txSt = hsp_pkg::TX_IDLE;
    endcase
    // receiver samples mid-bit; only the first stop bit is checked
    case (q.rxSt)
      hsp_pkg::RX_IDLE: begin
        if (!rxIn) begin
          n.rxSt  = hsp_pkg::RX_START;
          n.rxCnt = {1'b0, div[12:1]};
        end
      end
      hsp_pkg::RX_START, hsp_pkg::RX_DATA, hsp_pkg::RX_PAR: begin
        if (q.rxCnt != 13'h0000)
          n.rxCnt = q.rxCnt - 13'h0001;
        else begin
          n.rxCnt = div - 13'h0001;
          if (q.rxSt == hsp_pkg::RX_START) begin
            // a glitch shorter than half a bit is not a start
            n.rxSt  = rxIn ? hsp_pkg::RX_IDLE : hsp_pkg::RX_DATA;
            n.rxBit = 3'h0;
            n.rxPar = 1'b0;
          end else if (q.rxSt == hsp_pkg::RX_DATA) begin
            n.rxShift = {rxIn, q.rxShift[7:1]};
            n.rxPar   = q.rxPar ^ rxIn;
            n.rxBit   = q.rxBit + 3'h1;
            if (q.rxBit == 3'h7)
              n.rxSt = (q.cfg.parity != `HSP_PAR_NONE) ? hsp_pkg::RX_PAR
                                                       : hsp_pkg::RX_STOP;
          end else begin
            if ((q.rxPar ^ rxIn) != (q.cfg.parity == `HSP_PAR_ODD))
              n.rxParErr = 1'b1; // see R4
            n.rxSt = hsp_pkg::RX_STOP;
          end
        end
      end
      hsp_pkg::RX_STOP: begin
        if (q.rxCnt != 13'h0000)
          n.rxCnt = q.rxCnt - 13'h0001;
        else begin
          // delivery placed after the read pop so the new byte wins
          if (!rxIn)
            n.rxFrmErr = 1'b1;
          if (q.rxValid && n.rxValid)
            n.rxOvr = 1'b1;
          n.rxData  = q.rxShift;
          n.rxValid = 1'b1;
          n.rxSt    = hsp_pkg::RX_IDLE;
        end
      end
      default: n.rxSt = hsp_pkg::RX_IDLE;
    endcase
    // controller power state
    case (q.pwSt)
      hsp_pkg::PW_RUN:
        if (q.pwrMode == `HSP_PM2 && !dsrOn)
          n.pwSt = hsp_pkg::PW_STBY; // see R8
      hsp_pkg::PW_STBY:
        if (apPacket || dsrOn || q.pwrMode != `HSP_PM2)
          n.pwSt = hsp_pkg::PW_RUN; // see R9
      default: n.pwSt = hsp_pkg::PW_RUN;
    endcase
    // start-up delay, then flow control follows receive room
    if (q.readyCnt != 6'(`HSP_READY_CYC))
      n.readyCnt = q.readyCnt + 6'h01;
    n.ready = (q.readyCnt == 6'(`HSP_READY_CYC));
    n.rtsN  = !(q.ready && !n.rxValid && q.pwSt == hsp_pkg::PW_RUN); // see R5
    // synchronous reset, driven high by the host
    if (rst) begin // see R23
      n = '0;
      n.syn1    = 14'h3FFF;
      n.syn2    = 14'h3FFF;
      n.txSt    = hsp_pkg::TX_IDLE;
      n.txLine  = 1'b1;
      n.rxSt    = hsp_pkg::RX_IDLE;
      n.cfg     = {`HSP_BAUD_115200, `HSP_PAR_NONE, 1'b0}; // see R1
      n.pwSt    = hsp_pkg::PW_RUN;
      n.pwrMode = `HSP_PM5; // see R10
      n.lineDir = 12'h000; // see R22
      n.modem   = 5'b11100;
      n.rtsN    = 1'b1; // see R21
    end
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    q <= n;
  end

  // pins: modem functions own lines 10..13 while enabled
  always_comb begin
    lineOut = q.lineVal;
    lineOe  = q.lineDir;
    if (q.modem.on) begin // see R16
      lineOe[`HSP_IDX_DSR]  = 1'b0;
      lineOe[`HSP_IDX_DTR]  = 1'b1;
      lineOut[`HSP_IDX_DTR] = !q.ready;
      lineOe[`HSP_IDX_RI]   = q.modem.riOut; // see R18
      lineOut[`HSP_IDX_RI]  = q.modem.riLvl;
      lineOe[`HSP_IDX_DCD]  = q.modem.dcdOut;
      lineOut[`HSP_IDX_DCD] = q.modem.dcdLvl;
    end
  end

  assign busRdata    = q.rdData;
  assign serTxd      = q.txLine;
  assign rtsN        = q.rtsN;
  assign chipsetOn   = q.pwrMode != `HSP_PM5;
  assign chipsetDoze = q.pwrMode == `HSP_PM1 || q.pwrMode == `HSP_PM2; // see R13
  assign ctrlStandby = q.pwSt == hsp_pkg::PW_STBY;

  // checks
  property p_txHold;
    @(posedge sys_clk) disable iff (rst)
      q.txSt == hsp_pkg::TX_IDLE && !ctsOk |=> q.txSt == hsp_pkg::TX_IDLE;
  endproperty
  a_txHold: assert property (p_txHold) else $error("tx started without cts"); // see R6
  property p_rtsReset;
    @(posedge sys_clk) rst |=> rtsN && !q.ready;
  endproperty
  a_rtsReset: assert property (p_rtsReset) else $error("rts not held off"); // see R21
  property p_rtsRoom;
    @(posedge sys_clk) disable iff (rst) !rtsN |-> q.ready && !q.rxValid;
  endproperty
  a_rtsRoom: assert property (p_rtsRoom) else $error("rts low without room"); // see R5
  property p_pm5Only;
    @(posedge sys_clk) disable iff (rst)
      cmdWr && q.pwrMode == `HSP_PM5 && op >= `HSP_OP_OUT |=> q.respErr;
  endproperty
  a_pm5Only: assert property (p_pm5Only) else $error("mode 5 took command"); // see R11
  property p_pmLegal;
    @(posedge sys_clk) disable iff (rst)
      q.pwrMode inside {`HSP_PM0, `HSP_PM1, `HSP_PM2, `HSP_PM5};
  endproperty
  a_pmLegal: assert property (p_pmLegal) else $error("illegal power mode"); // see R12
  property p_adhocPm1;
    @(posedge sys_clk) disable iff (rst)
      cmdWr && op == `HSP_OP_PWR && arg[2:0] == `HSP_PM1 && q.adhoc
      |=> q.respErr && $stable(q.pwrMode);
  endproperty
  a_adhocPm1: assert property (p_adhocPm1) else $error("mode 1 in ad-hoc"); // see R14
  property p_sleep;
    @(posedge sys_clk) disable iff (rst)
      q.pwSt == hsp_pkg::PW_RUN && q.pwrMode == `HSP_PM2 && !dsrOn
      |=> ctrlStandby;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no standby"); // see R8
  property p_wake;
    @(posedge sys_clk) disable iff (rst) ctrlStandby && apPacket |=> !ctrlStandby;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on packet"); // see R9
  property p_lenOnly8;
    @(posedge sys_clk) disable iff (rst)
      cmdWr && op == `HSP_OP_SERCFG && arg[6:3] != `HSP_WORD_LEN
      |=> q.respErr && $stable(q.cfg);
  endproperty
  a_lenOnly8: assert property (p_lenOnly8) else $error("bad length taken"); // see R3
  property p_stopHigh;
    @(posedge sys_clk) disable iff (rst) q.txSt == hsp_pkg::TX_STOP |-> serTxd;
  endproperty
  a_stopHigh: assert property (p_stopHigh) else $error("stop bit low"); // see R4
  property p_resetLines;
    @(posedge sys_clk) rst |=> lineOe[7:0] == 8'h00 && chipsetOn == 1'b0;
  endproperty
  a_resetLines: assert property (p_resetLines) else $error("reset lines"); // see R22
  c_txChar: cover property (@(posedge sys_clk) q.txSt == hsp_pkg::TX_STOP);
  c_rxChar: cover property (@(posedge sys_clk) q.rxSt == hsp_pkg::RX_STOP ##1 q.rxValid);
  c_standby: cover property (@(posedge sys_clk) ctrlStandby ##1 !ctrlStandby);
  c_pm1: cover property (@(posedge sys_clk) q.pwrMode == `HSP_PM1);
endmodule : hsp_serial_port

/* hsp_host_model.sv */
// host-side partner: takes device serial output, sends characters to it
// assumes 8N1 framing at divisor DIV, same clock as the device
`timescale 1ns/100ps
module hsp_host_model #(
  parameter int DIV = 434
) (
  input  wire logic sys_clk,
  input  wire logic serTxd,
  input  wire logic rtsN,
  output logic      serRxd
);
  logic [7:0] rxByte;
  int         rxCount;
  // receiver: sample mid-bit, lsb first, count only well-framed chars
  initial begin
    serRxd  = 1'b1;
    rxCount = 0;
    forever begin
      @(negedge serTxd);
      repeat (DIV / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge sys_clk);
        rxByte[i] = serTxd;
      end
      repeat (DIV) @(posedge sys_clk);
      if (serTxd) rxCount++;
    end
  end
  // one character, held back while the device cannot take it
  task automatic sendByte(input logic [7:0] b);
    while (rtsN !== 1'b0) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      serRxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (DIV) @(posedge sys_clk);
    end
  endtask : sendByte
endmodule : hsp_host_model

/* hsp_serial_port_tb_top.sv */
// self-checking bench: register tasks, host partner, port checks
// assumes hsp_cfg.svh on the include path and a 50 MHz sys_clk
`timescale 1ns/100ps
`include "hsp_cfg.svh"
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin \
  num_errors++; $display("Error %s expected %0h seen %0h", nm, ex, ac); \
  end end
module hsp_serial_port_tb_top;
  localparam logic [23:0] VER_ID = 24'h00A5C3; // arbitrary value
  localparam logic [23:0] HW_ID  = 24'h3C5A01; // arbitrary value
  logic                  sys_clk, rst, serRxd, serTxd, ctsN, rtsN;
  logic                  apPacket, chipsetOn, chipsetDoze, ctrlStandby;
  logic [11:0]           lineIn, lineOut, lineOe;
  logic [31:0]           busRdata, s;
  hsp_pkg::hsp_bus_req_t busReq;
  int                    num_errors, compares, cyc, n;
  hsp_serial_port #(.HW_ADDR(HW_ID), .VERSION(VER_ID)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .serRxd(serRxd), .serTxd(serTxd), .ctsN(ctsN), .rtsN(rtsN),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
    .apPacket(apPacket), .chipsetOn(chipsetOn),
    .chipsetDoze(chipsetDoze), .ctrlStandby(ctrlStandby));
  hsp_host_model #(.DIV(`HSP_DIV(115200))) i_host (
    .sys_clk(sys_clk), .serTxd(serTxd), .rtsN(rtsN), .serRxd(serRxd));
  // clock and hang guard; the ceiling leaves room for two characters
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask : wrReg
  // read data stand only in the cycle after the strobe
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 d = busRdata;
  endtask : rdReg
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg,
                     input logic err);
    wrReg(`HSP_REG_CMD, {arg, op});
    rdReg(`HSP_REG_STATUS, s);
    `CHK("respErr", err, s[0])
  endtask : cmd
  task automatic summarize;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    {sys_clk, apPacket, num_errors, compares, cyc} = '0;
    {rst, ctsN} = 2'b11;
    busReq = '0;
    lineIn = 12'h000;
    repeat (12) @(posedge sys_clk);
    #1 `CHK("rtsN", 1'b1, rtsN)
    `CHK("lineOe", 12'hE00, lineOe)
    `CHK("chipsetOn", 1'b0, chipsetOn)
    `CHK("serTxd", 1'b1, serTxd)
    @(posedge sys_clk) rst <= 1'b0;
    for (int i = 0; i < 100 && rtsN !== 1'b0; i++) @(posedge sys_clk);
    `CHK("rtsN", 1'b0, rtsN)
    rdReg(`HSP_REG_STATUS, s);
    `CHK("mode", {`HSP_PM5, 2'h1}, s[5:1])
    rdReg(`HSP_REG_CFG, s);
    `CHK("cfg", {`HSP_BAUD_115200, `HSP_PAR_NONE, 1'b0}, s[5:0])
    cmd(`HSP_OP_OUT, 24'h1, 1'b1);
    rdReg(`HSP_REG_LINES, s);
    `CHK("dir", 12'h000, s[23:12])
    cmd(`HSP_OP_VER, 24'h0, 1'b0);
    rdReg(`HSP_REG_RESP, s);
    `CHK("resp", VER_ID, s[23:0])
    cmd(`HSP_OP_HWADDR, 24'h0, 1'b0);
    rdReg(`HSP_REG_RESP, s);
    `CHK("hwAddr", HW_ID, s[23:0])
    cmd(`HSP_OP_PWR, 24'h3, 1'b1);
    cmd(`HSP_OP_SERCFG, 24'h3C, 1'b1);
    cmd(`HSP_OP_SERCFG, 24'h2C4, 1'b0);
    rdReg(`HSP_REG_CFG, s);
    `CHK("cfg", 6'h23, s[5:0])
    cmd(`HSP_OP_SERCFG, 24'h44, 1'b0);
    cmd(`HSP_OP_PWR, 24'h1, 1'b0);
    `CHK("doze", 2'h3, {chipsetOn, chipsetDoze})
    cmd(`HSP_OP_BSS, 24'h1, 1'b1);
    cmd(`HSP_OP_PWR, 24'h0, 1'b0);
    cmd(`HSP_OP_BSS, 24'h1, 1'b0);
    cmd(`HSP_OP_PWR, 24'h1, 1'b1);
    cmd(`HSP_OP_BSS, 24'h0, 1'b0);
    // key length, region-limited channel and an unlisted rate
    cmd(`HSP_OP_KEY, 24'h0B, 1'b1);
    cmd(`HSP_OP_KEY, 24'h1A, 1'b0);
    cmd(`HSP_OP_CHAN, 24'h0C, 1'b1);
    cmd(`HSP_OP_REGION, 24'h1, 1'b0);
    cmd(`HSP_OP_CHAN, 24'h0D, 1'b0);
    cmd(`HSP_OP_SERCFG, 24'h47, 1'b1);
    rdReg(`HSP_REG_CFG, s);
    `CHK("keyChan", 7'h6D, s[17:11])
    `CHK("cfg", 6'h20, s[5:0])
    cmd(`HSP_OP_OUT, 24'h00F, 1'b0);
    cmd(`HSP_OP_HIGH, 24'h005, 1'b0);
    cmd(`HSP_OP_LOW, 24'h001, 1'b0);
    `CHK("oe", 12'hE0F, lineOe)
    `CHK("out", 4'h4, lineOut[3:0])
    cmd(`HSP_OP_OUT, 24'h100, 1'b1);
    @(posedge sys_clk) lineIn <= 12'h0A0;
    repeat (4) @(posedge sys_clk);
    cmd(`HSP_OP_SAMPLE, 24'h0F0, 1'b0);
    rdReg(`HSP_REG_RESP, s);
    `CHK("sample", 24'h0A0, s[23:0])
    // transmit held while the host withholds clear-to-send
    n = i_host.rxCount;
    wrReg(`HSP_REG_TXDATA, 32'h5A);
    repeat (50) @(posedge sys_clk);
    `CHK("idle", 1'b1, serTxd)
    ctsN <= 1'b0;
    for (int i = 0; i < 6000 && i_host.rxCount == n; i++)
      @(posedge sys_clk);
    `CHK("txByte", 8'h5A, i_host.rxByte)
    i_host.sendByte(8'hC3);
    rdReg(`HSP_REG_RXDATA, s);
    `CHK("rxByte", 9'h1C3, s[8:0])
    // standby follows the sleep-permit line in mode 2
    cmd(`HSP_OP_PWR, 24'h2, 1'b0);
    @(posedge sys_clk) lineIn <= 12'h1A0;
    repeat (6) @(posedge sys_clk);
    `CHK("stby", 1'b1, ctrlStandby)
    lineIn <= 12'h0A0;
    repeat (6) @(posedge sys_clk);
    `CHK("stby", 1'b0, ctrlStandby)
    // a packet wakes the controller; permit still released, so it resleeps
    lineIn <= 12'h1A0;
    repeat (6) @(posedge sys_clk);
    apPacket <= 1'b1;
    @(posedge sys_clk) apPacket <= 1'b0;
    @(posedge sys_clk) `CHK("wake", 1'b0, ctrlStandby)
    @(posedge sys_clk) `CHK("resleep", 1'b1, ctrlStandby)
    summarize();
  end
endmodule : hsp_serial_port_tb_top
